/* common/eag_params.svh */
// constants for the e1 alarm generation block: offsets, fields, resets
// assumes a 32-bit axi4-lite register bus, byte addresses
`ifndef EAG_PARAMS_SVH
`define EAG_PARAMS_SVH
`define EAG_OFS_CTRL0     8'h00
`define EAG_OFS_CTRL1     8'h04
`define EAG_OFS_STATUS    8'h08
`define EAG_OFS_CLEAR     8'h0c
`define EAG_OFS_ENABLE    8'h10
`define EAG_OFS_DEFECT    8'h14
`define EAG_CTRL_RESET    8'h00
`define EAG_YEL_LSB       4
`define EAG_AIS_PATTERN_SELECT_LSB      2
`define EAG_AIS_DETECT_CRITERIA_LSB      0
`define EAG_YEL_AUTO      2'h1
`define EAG_YEL_FORCE     2'h3
`define EAG_AIS_PATTERN_SELECT_NONE     2'h0
`define EAG_AIS_PATTERN_SELECT_UNFRAMED 2'h1
`define EAG_AIS_PATTERN_SELECT_TS16     2'h2
`define EAG_AIS_PATTERN_SELECT_FRAMED   2'h3
`define EAG_AIS_DETECT_CRITERIA_NONE     2'h0
`define EAG_AIS_DETECT_CRITERIA_ANY      2'h1
`define EAG_AIS_DETECT_CRITERIA_TS16     2'h2
`define EAG_AIS_DETECT_CRITERIA_FRAMED   2'h3
`define EAG_TS0           5'h00
`define EAG_TS16          5'h10
`define EAG_YEL_BIT       3'h2
`define EAG_MFYEL_BIT     3'h5
`define EAG_RESP_OKAY     2'h0
`define EAG_RESP_SLVERR   2'h2
`endif

/* common/eag_pkg.sv */
// types for the e1 alarm generation block
// assumes eag_params.svh supplies the numbers
package eag_pkg;
	// per-channel control byte
	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] yellowMode;
		logic [1:0] aisPatternSel;
		logic [1:0] aisDetectCrit;
	} eag_ctrl_type;
	// transmit timing position of the current bit
	typedef struct packed {
		logic       nonAlignFrame;
		logic       framingBit;
		logic [3:0] mfFrame;
		logic [4:0] timeslot;
		logic [2:0] bitIndex;
	} eag_txpos_type;
	// receive pattern indications from the receive framer
	typedef struct packed {
		logic lossOfFrame;
		logic lossOfCasMf;
		logic unframedOnes;
		logic framedOnes;
		logic ts16Ones;
	} eag_rxind_type;
	typedef enum logic [2:0] {
		EAG_RD_IDLE = 3'b001,
		EAG_RD_RESP = 3'b010,
		EAG_RD_HOLD = 3'b100
	} eag_rd_type;
endpackage

/* rtl/eag_alarm_gen.sv */
// two-channel e1 alarm generation and ais control, axi4-lite register file
// assumes framer timing and receive indications synchronous to ref_clk
//
// Overview of operation
// [RQ1] Auto yellow mode drives bit 3 of timeslot 0 in non-alignment frames high while loss of frame is declared.
// [RQ2] Auto yellow mode drives bit 6 of timeslot 16 in multiframe frame 0 high while loss of CAS multiframe is declared.
// [RQ3] Forced yellow mode sends both yellow bits as one regardless of receive state.
// [RQ4] The yellow field is bits 5-4, resets to 00, and codes 00 and 10 send no yellow.
// [RQ5] Ais select 00 passes normal traffic untouched.
// [RQ6] Ais select 01 replaces every outbound bit with one, framing included.
// [RQ7] Ais select 10 forces every bit of timeslot 16 to one.
// [RQ8] Ais select 11 sends all-ones payload while keeping framing bits.
// [RQ9] The ais select field is bits 3-2 and resets to 00, the normal setting.
// [RQ10] The detection criteria field is bits 1-0, resets to 00, and picks the patterns that declare ais.
// [RQ11] Criteria 00 never declares ais.
// [RQ12] Criteria 01 declares ais on unframed or framed all ones.
// [RQ13] Criteria 10 declares ais on all ones in timeslot 16.
// [RQ14] Criteria 11 declares ais only on framed all ones.
// [RQ15] Timeslot-16 ais is always monitored and reported with interrupt status, whatever the criteria.
// [RQ16] Each of the two channels keeps its own control register and alarm logic.
`timescale 1ns/1ns
`include "eag_params.svh"
module eag_alarm_gen (
	// clock, reset, enable
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	input  wire logic                     clkEn,
	// axi4-lite write address and data
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// transmit stream, per channel
	input  wire eag_pkg::eag_txpos_type   txPos [2],
	input  wire logic [1:0]               txDataIn,
	output logic [1:0]                    txDataOut,
	// receive indications, per channel
	input  wire eag_pkg::eag_rxind_type   rxInd [2],
	output logic [1:0]                    aisDefect,
	output logic [1:0]                    ts16AlarmIndication,
	// interrupt
	output logic                          irq
);
	eag_pkg::eag_ctrl_type ctrl_ff [2];
	logic [3:0]  status_ff;
	logic [3:0]  enable_ff;
	logic [3:0]  nxt_status;
	logic [1:0]  txData_ff;
	logic [1:0]  aisDefect_ff;
	logic [1:0]  ts16Alarm_ff;
	logic [1:0]  nxt_ais;
	logic [1:0]  nxt_ts16;
	logic [1:0]  nxt_tx;
	logic        awHeld_ff;
	logic        wHeld_ff;
	logic [7:0]  awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0]  wStrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        doWrite;
	logic [7:0]  wrAddr;
	logic [31:0] wrData;
	logic        wrLane0;
	eag_pkg::eag_rd_type rdState_ff;

	// write channel capture, either order
	assign s_axi_awready = clkEn && !awHeld_ff && !bvalid_ff;
	assign s_axi_wready  = clkEn && !wHeld_ff && !bvalid_ff;
	assign wrAddr  = awHeld_ff ? awAddr_ff : s_axi_awaddr;
	assign wrData  = wHeld_ff ? wData_ff : s_axi_wdata;
	assign wrLane0 = wHeld_ff ? wStrb_ff[0] : s_axi_wstrb[0];
	assign doWrite = clkEn && !bvalid_ff
		&& (awHeld_ff || s_axi_awvalid) && (wHeld_ff || s_axi_wvalid);

	// hold address or data that arrives before its partner
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff  <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff  <= 32'h0;
			wStrb_ff  <= 4'h0;
		end else if (clkEn) begin
			if (doWrite) begin
				awHeld_ff <= 1'b0;
				wHeld_ff  <= 1'b0;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					awHeld_ff <= 1'b1;
					awAddr_ff <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					wHeld_ff <= 1'b1;
					wData_ff <= s_axi_wdata;
					wStrb_ff <= s_axi_wstrb;
				end
			end
		end
	end

	// write response, slverr on unmapped address
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `EAG_RESP_OKAY;
		end else if (clkEn) begin
			if (doWrite) begin
				bvalid_ff <= 1'b1;
				case (wrAddr)
					`EAG_OFS_CTRL0, `EAG_OFS_CTRL1, `EAG_OFS_CLEAR,
					`EAG_OFS_ENABLE: bresp_ff <= `EAG_RESP_OKAY;
					`EAG_OFS_STATUS, `EAG_OFS_DEFECT:
						bresp_ff <= `EAG_RESP_OKAY;
					default: bresp_ff <= `EAG_RESP_SLVERR;
				endcase
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// control registers, one per channel
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_ff[0] <= `EAG_CTRL_RESET; // RQ4
			ctrl_ff[1] <= `EAG_CTRL_RESET; // RQ9
		end else if (doWrite && wrLane0) begin
			if (wrAddr == `EAG_OFS_CTRL0)
				ctrl_ff[0] <= wrData[7:0]; // RQ16
			if (wrAddr == `EAG_OFS_CTRL1)
				ctrl_ff[1] <= wrData[7:0]; // RQ16
		end
	end

	// interrupt enable register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			enable_ff <= 4'h0;
		end else if (doWrite && wrLane0 && wrAddr == `EAG_OFS_ENABLE) begin
			enable_ff <= wrData[3:0];
		end
	end

	// per-channel transmit insertion and receive detection
	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			eag_pkg::eag_txpos_type p;
			logic yelBit;
			logic mfYelBit;
			logic bit0;
			p = txPos[ch];
			bit0 = txDataIn[ch];
			yelBit = p.nonAlignFrame && p.timeslot == `EAG_TS0
				&& p.bitIndex == `EAG_YEL_BIT;
			mfYelBit = p.mfFrame == 4'h0 && p.timeslot == `EAG_TS16
				&& p.bitIndex == `EAG_MFYEL_BIT;
			// yellow insertion; codes 00 and 10 leave traffic alone
			case (ctrl_ff[ch].yellowMode)
				`EAG_YEL_AUTO: begin
					if (yelBit && rxInd[ch].lossOfFrame)
						bit0 = 1'b1; // RQ1
					if (mfYelBit && rxInd[ch].lossOfCasMf)
						bit0 = 1'b1; // RQ2
				end
				`EAG_YEL_FORCE: begin
					if (yelBit || mfYelBit)
						bit0 = 1'b1; // RQ3
				end
				default: bit0 = bit0; // RQ4
			endcase
			// ais pattern replacement
			case (ctrl_ff[ch].aisPatternSel)
				`EAG_AIS_PATTERN_SELECT_NONE: bit0 = bit0; // RQ5
				`EAG_AIS_PATTERN_SELECT_UNFRAMED: bit0 = 1'b1; // RQ6
				`EAG_AIS_PATTERN_SELECT_TS16: begin
					if (p.timeslot == `EAG_TS16)
						bit0 = 1'b1; // RQ7
				end
				`EAG_AIS_PATTERN_SELECT_FRAMED: begin
					if (!p.framingBit)
						bit0 = 1'b1; // RQ8
				end
				default: bit0 = bit0;
			endcase
			nxt_tx[ch] = bit0;
			// ais declaration per criteria
			case (ctrl_ff[ch].aisDetectCrit) // RQ10
				`EAG_AIS_DETECT_CRITERIA_NONE: nxt_ais[ch] = 1'b0; // RQ11
				`EAG_AIS_DETECT_CRITERIA_ANY: nxt_ais[ch] =
					rxInd[ch].unframedOnes || rxInd[ch].framedOnes; // RQ12
				`EAG_AIS_DETECT_CRITERIA_TS16: nxt_ais[ch] = rxInd[ch].ts16Ones; // RQ13
				`EAG_AIS_DETECT_CRITERIA_FRAMED: nxt_ais[ch] = rxInd[ch].framedOnes; // RQ14
				default: nxt_ais[ch] = 1'b0;
			endcase
			nxt_ts16[ch] = rxInd[ch].ts16Ones; // RQ15
		end
	end

	// registered stream and defect outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txData_ff    <= 2'h0;
			aisDefect_ff <= 2'h0;
			ts16Alarm_ff <= 2'h0;
		end else if (clkEn) begin
			txData_ff    <= nxt_tx;
			aisDefect_ff <= nxt_ais;
			ts16Alarm_ff <= nxt_ts16;
		end
	end
	assign txDataOut           = txData_ff;
	assign aisDefect           = aisDefect_ff;
	assign ts16AlarmIndication = ts16Alarm_ff;

	// sticky status: bits 1:0 ais rise, bits 3:2 ts16 rise; set beats clear
	always_comb begin
		nxt_status = status_ff;
		if (doWrite && wrLane0 && wrAddr == `EAG_OFS_CLEAR)
			nxt_status = nxt_status & ~wrData[3:0];
		nxt_status = nxt_status | {nxt_ts16 & ~ts16Alarm_ff,
			nxt_ais & ~aisDefect_ff};
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_ff <= 4'h0;
		end else if (clkEn) begin
			status_ff <= nxt_status; // RQ15
		end
	end
	assign irq = |(status_ff & enable_ff);

	// read channel
	assign s_axi_arready = clkEn && rdState_ff == eag_pkg::EAG_RD_IDLE;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdState_ff <= eag_pkg::EAG_RD_IDLE;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0;
			rresp_ff   <= `EAG_RESP_OKAY;
		end else if (clkEn) begin
			case (rdState_ff)
				eag_pkg::EAG_RD_IDLE: begin
					if (s_axi_arvalid) begin
						rdState_ff <= eag_pkg::EAG_RD_RESP;
						rvalid_ff  <= 1'b1;
						rresp_ff   <= `EAG_RESP_OKAY;
						case (s_axi_araddr)
							`EAG_OFS_CTRL0:  rdata_ff <= {24'h0, ctrl_ff[0]};
							`EAG_OFS_CTRL1:  rdata_ff <= {24'h0, ctrl_ff[1]};
							`EAG_OFS_STATUS: rdata_ff <= {28'h0, status_ff};
							`EAG_OFS_CLEAR:  rdata_ff <= 32'h0;
							`EAG_OFS_ENABLE: rdata_ff <= {28'h0, enable_ff};
							`EAG_OFS_DEFECT: rdata_ff <=
								{28'h0, ts16Alarm_ff, aisDefect_ff};
							default: begin
								rdata_ff <= 32'h0;
								rresp_ff <= `EAG_RESP_SLVERR;
							end
						endcase
					end
				end
				eag_pkg::EAG_RD_RESP: begin
					if (s_axi_rready) begin
						rvalid_ff  <= 1'b0;
						rdState_ff <= eag_pkg::EAG_RD_IDLE;
					end
				end
				default: begin
					rvalid_ff  <= 1'b0;
					rdState_ff <= eag_pkg::EAG_RD_IDLE;
				end
			endcase
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;
endmodule

/* sim/eag_alarm_gen_props.sv */
// checker: channel 0 stream insertion and defect relations
// assumes address and data of a write are offered together
`timescale 1ns/1ns
`include "eag_params.svh"
module eag_alarm_gen_props (
	// clock and reset
	input wire logic                   ref_clk,
	input wire logic                   rst,
	// register writes
	input wire logic [7:0]             s_axi_awaddr,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic [31:0]            s_axi_wdata,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	// stream and receive side
	input wire eag_pkg::eag_txpos_type txPos [2],
	input wire logic [1:0]             txDataIn,
	input wire logic [1:0]             txDataOut,
	input wire eag_pkg::eag_rxind_type rxInd [2],
	input wire logic [1:0]             aisDefect
);
	logic [7:0]             ctl_ff;
	logic [1:0]             yellow_alarm_mode, sel, crit;
	eag_pkg::eag_txpos_type p;
	assign {yellow_alarm_mode, sel, crit} = ctl_ff[5:0];
	assign p = txPos[0];
	// shadow of the channel 0 control byte
	always_ff @(posedge ref_clk) begin
		if (rst)
			ctl_ff <= 8'h00;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
			&& s_axi_wready && s_axi_awaddr == `EAG_OFS_CTRL0)
			ctl_ff <= s_axi_wdata[7:0];
	end
	// yellow slot: bit 3 of timeslot 0 in a non-alignment frame
	sequence yelSlot;
		p.nonAlignFrame && p.timeslot == `EAG_TS0
			&& p.bitIndex == `EAG_YEL_BIT;
	endsequence
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_yellow_off: assert property (
		sel == 2'h0 && !yellow_alarm_mode[0] |=> txDataOut[0] == $past(txDataIn[0]))
		else $error("outbound bit altered with nothing enabled");
	a_unframed_ones: assert property (
		sel == 2'h1 |=> txDataOut[0]) else $error("unframed ais bit low");
	a_ts16_ones: assert property (
		sel == 2'h2 && p.timeslot == `EAG_TS16 |=> txDataOut[0])
		else $error("timeslot 16 bit low");
	a_payload_ones: assert property (
		sel == 2'h3 && !p.framingBit |=> txDataOut[0])
		else $error("framed ais payload bit low");
	a_force_yellow: assert property (
		(sel == 2'h0 && yellow_alarm_mode == 2'h3) ##0 yelSlot |=> txDataOut[0])
		else $error("forced yellow bit low");
	a_auto_yellow: assert property (
		(sel == 2'h0 && yellow_alarm_mode == 2'h1 && rxInd[0].lossOfFrame) ##0 yelSlot
		|=> txDataOut[0]) else $error("automatic yellow bit low");
	a_auto_mfyellow: assert property (
		sel == 2'h0 && yellow_alarm_mode == 2'h1 && rxInd[0].lossOfCasMf
		&& p.timeslot == `EAG_TS16 && p.mfFrame == 4'h0
		&& p.bitIndex == `EAG_MFYEL_BIT |=> txDataOut[0])
		else $error("multiframe yellow bit low");
	a_no_defect: assert property (
		crit == 2'h0 |=> !aisDefect[0]) else $error("defect while disabled");
endmodule

/* sim/eag_alarm_gen_tb_top.sv */
// bench: register access, defect table, interrupt and stream sweeps
// assumes the checker and far-end model are compiled ahead of it
`timescale 1ns/1ns
`include "eag_params.svh"
module eag_alarm_gen_tb_top;
	logic                   ref_clk = 1'b0;
	logic                   rst = 1'b1;
	logic [7:0]             s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata;
	logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic                   s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic                   s_axi_rready = 1'b0, s_axi_awready;
	logic                   s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                   s_axi_rvalid, irq;
	logic [1:0]             s_axi_bresp, s_axi_rresp, txDataIn, txDataOut;
	logic [1:0]             aisDefect, ts16AlarmIndication;
	eag_pkg::eag_txpos_type txPos [2];
	eag_pkg::eag_rxind_type rxInd [2] = '{default: '0};
	int                     errors = 0, samples_checked = 0;
	int                     c, s, ones0, ones1;
	int                     cntTab [7] = '{2048, 2057, 2048, 2057, 4096,
		2112, 4064};
	always #4 ref_clk = ~ref_clk;
	// design with clock enable and byte lane 0 held on
	eag_alarm_gen eag_alarm_gen_inst (
		.ref_clk, .rst, .clkEn(1'b1), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txPos, .txDataIn,
		.txDataOut, .rxInd, .aisDefect, .ts16AlarmIndication, .irq);
	eag_far_end eag_far_end_inst (.ref_clk, .rst, .txPos, .txDataIn);
	// compare one value and count it
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// a bus wait that ran out ends the run
	task automatic guard(input int k);
		if (k >= 64) begin
			errors++;
			test_done();
		end
	endtask
	// one write: address and data together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64 && !(s_axi_bvalid && s_axi_bready); n++) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		guard(n);
		// mapped word offsets answer okay, anything else slverr
		chk("write resp", s_axi_bresp,
			a <= `EAG_OFS_DEFECT && a[1:0] == 2'h0
			? `EAG_RESP_OKAY : `EAG_RESP_SLVERR);
	endtask
	// one read, data and response compared
	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] rexp);
		int n;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64 && !(s_axi_rvalid && s_axi_rready); n++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		guard(n);
		chk("read data", s_axi_rdata, exp);
		chk("read resp", s_axi_rresp, rexp);
	endtask
	// verdict and end of run
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`EAG_OFS_CTRL0, 32'h0, `EAG_RESP_OKAY);
		wr(`EAG_OFS_CTRL1, 32'h2a);
		rd(`EAG_OFS_CTRL1, 32'h2a, `EAG_RESP_OKAY);
		rd(`EAG_OFS_CTRL0, 32'h0, `EAG_RESP_OKAY);
		rd(8'h40, 32'h0, `EAG_RESP_SLVERR);
		wr(8'h40, 32'h0);
		// every criteria code against each received pattern
		for (c = 0; c < 12; c++) begin
			wr(`EAG_OFS_CTRL0, c / 3);
			rxInd[0] <= eag_pkg::eag_rxind_type'(5'h04 >> (c % 3));
			repeat (3) @(posedge ref_clk);
			chk("ais", aisDefect[0], 12'h518 >> c & 1);
			chk("ts16", ts16AlarmIndication[0], c % 3 == 2);
		end
		// both ais and timeslot-16 rises of channel 0 were latched
		rd(`EAG_OFS_STATUS, 32'h5, `EAG_RESP_OKAY);
		// raise, mask and clear the ais event of channel 0
		wr(`EAG_OFS_CTRL0, `EAG_AIS_DETECT_CRITERIA_ANY);
		rxInd[0] <= '0;
		wr(`EAG_OFS_CLEAR, 32'hf);
		wr(`EAG_OFS_ENABLE, 32'h1);
		rd(`EAG_OFS_STATUS, 32'h0, `EAG_RESP_OKAY);
		rxInd[0] <= eag_pkg::eag_rxind_type'(5'h04);
		repeat (3) @(posedge ref_clk);
		chk("irq", irq, 1);
		rd(`EAG_OFS_DEFECT, 32'h1, `EAG_RESP_OKAY);
		rxInd[0] <= '0;
		rd(`EAG_OFS_STATUS, 32'h1, `EAG_RESP_OKAY);
		wr(`EAG_OFS_ENABLE, 32'h0);
		chk("irq masked", irq, 0);
		wr(`EAG_OFS_CLEAR, 32'h1);
		wr(`EAG_OFS_ENABLE, 32'h1);
		chk("irq cleared", irq, 0);
		// yellow codes with both losses, then each ais pattern
		rxInd[0] <= eag_pkg::eag_rxind_type'(5'h18);
		for (s = 0; s < 7; s++) begin
			wr(`EAG_OFS_CTRL0, s < 4 ? s << 4 : s - 3 << 2);
			repeat (8) @(posedge ref_clk);
			ones0 = 0;
			ones1 = 0;
			repeat (4096) begin
				@(posedge ref_clk);
				ones0 += txDataOut[0];
				ones1 += txDataOut[1];
			end
			chk("ones ch0", ones0, cntTab[s]);
			chk("ones ch1", ones1, 2112);
		end
		test_done();
	end
endmodule
bind eag_alarm_gen eag_alarm_gen_props eag_alarm_gen_props_inst (
	.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .txPos, .txDataIn,
	.txDataOut, .rxInd, .aisDefect);

/* sim/eag_far_end.sv */
// far-end model: transmit timing and outbound bits for both channels
// assumes one bit per ref_clk, 32 timeslots, 16-frame multiframe
`timescale 1ns/1ns
module eag_far_end (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// timing and data towards the block
	output eag_pkg::eag_txpos_type txPos [2],
	output logic [1:0]             txDataIn
);
	logic [11:0]            bitCnt_ff;
	eag_pkg::eag_txpos_type pos;
	// bit, timeslot and frame count of one multiframe
	always_ff @(posedge ref_clk) begin
		if (rst)
			bitCnt_ff <= 12'h000;
		else
			bitCnt_ff <= bitCnt_ff + 12'h001;
	end
	// odd frames carry no alignment word; timeslot 0 of even ones does
	assign pos = {bitCnt_ff[8], !bitCnt_ff[8] && bitCnt_ff[7:3] == 5'h00,
		bitCnt_ff};
	assign txPos[0] = pos;
	assign txPos[1] = pos;
	// half ones, zero at both yellow slots so forced bits add to the count
	assign txDataIn = {2{bitCnt_ff[0] ^ bitCnt_ff[2] ^ bitCnt_ff[3]}};
endmodule
